// ### mpc_parity_halt.sv
// mpc_parity_halt: checks even parity of memory words as they shift
// out of the register, halts and locks up on error, with an
// Avalon-MM register slave and a level interrupt.
// assumes timing pulses and word signals share clk_in; panel
// switches are asynchronous and are synchronised here.
//
// Summary of operation
// - preset tracker from parity bit, toggle per one
// - tracker set at phase end halts if selected
// - stored words carry even count of ones
// - tracker and halt lock each other set
// - error lamp lit when tracker and halt set
// - lockup blocks control switch, run drops
// - halt freezes tracker; continue clears it
// - phase-5 instruction codes skip checking
// - unused phase-5 codes also skip checking
// - time-share buffer words are not checked
// - interrupt restart needs tracker clear
// - first word after start or step unchecked
// - guard set at idle phase end or step
// - guard cleared after first fetch phase
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
module mpc_parity_halt (
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  // sequencer timing and word information
  input  wire mpc_pkg::mpc_timing_t timing_in,
  input  wire mpc_pkg::mpc_word_t   word_in,
  // operator panel switches, asynchronous
  input  wire logic                parity_halt_select_in,
  input  wire logic                control_switch_run_in,
  input  wire logic                control_switch_step_in,
  // panel lamps and machine status
  output logic                     parity_error_out,
  output logic                     halt_lamp_out,
  output logic                     halt_flag_out,
  output logic                     run_flag_out,
  output logic                     irq_out,
  // avalon-mm slave
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest
);

  mpc_pkg::mpc_state_t s_q;
  mpc_pkg::mpc_state_t s_d;

  logic [mpc_pkg::PANEL_WIDTH-1:0] panel_raw;
  logic [mpc_pkg::PANEL_WIDTH-1:0] panel;
  logic                            halt_select;
  logic                            sw_run;
  logic                            sw_step;

  // panel switches pass four flip-flops before use
  assign panel_raw = {control_switch_step_in, control_switch_run_in,
                      parity_halt_select_in};

  mpc_panel_sync u_sync (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .raw_in     (panel_raw),
    .stable_out (panel)
  );

  assign halt_select = panel[0];
  assign sw_run      = panel[1];
  assign sw_step     = panel[2];

  // one comparator per phase-5 operation code
  logic [mpc_pkg::NUM_HOLD_OPS-1:0] hold_hit;
  logic                             hold_op;

  genvar gi;
  generate
    for (gi = 0; gi < mpc_pkg::NUM_HOLD_OPS; gi = gi + 1) begin : g_hold
      assign hold_hit[gi] = (word_in.op_code == mpc_pkg::HOLD_OPS[gi]);
    end
  endgenerate

  // the register cannot shift in phase 5, so those codes are exempt
  assign hold_op = |hold_hit;

  // checked-phase qualifiers
  logic check_en;
  logic checked;
  logic lockup;
  logic tracker_next;
  logic halt_set;
  logic halt_clear;
  logic bus_req;
  logic bus_take;

  assign check_en = s_q.control[mpc_pkg::CTL_CHECK_EN];

  // fetch is checked only past the guard; exec unless phase 5
  assign checked = check_en && !word_in.timeshare_cycle
                && ((word_in.fetch_phase && !s_q.first_word_guard)
                 || (word_in.exec_check_phase && !hold_op));

  assign lockup = s_q.parity_tracker && s_q.halt_flag;

  assign bus_req  = avs_read || avs_write;
  assign bus_take = bus_req && (s_q.bus == mpc_pkg::MPC_BUS_ANSWER);

  // parity tracker: halt freezes it; continue releases by clearing
  always_comb begin
    tracker_next = s_q.parity_tracker;
    if (s_q.halt_flag) begin
      if (!halt_select) begin
        tracker_next = 1'b0;
      end
    end else if (timing_in.phase_end_pulse && !word_in.timeshare_cycle) begin
      // an odd word still held in the tracker stays set, so it locks with halt
      tracker_next = word_in.memory_parity_bit || halt_set;
    end else if (!s_q.run_flag && timing_in.end_of_word_pulse) begin
      tracker_next = 1'b0;
    end else if (checked && timing_in.bit_window) begin
      // every one leaving the register flips it: even count ends clear
      tracker_next = s_q.parity_tracker ^ word_in.register_serial_out;
    end else if (!checked && timing_in.q1_pulse && !word_in.timeshare_cycle) begin
      tracker_next = 1'b0;
    end
  end

  // halt set on odd parity; clears only when the tracker is clear
  assign halt_set = s_q.parity_tracker && timing_in.phase_end_pulse
                 && !word_in.timeshare_cycle && halt_select;

  assign halt_clear = !s_q.parity_tracker
                   && ((timing_in.end_of_word_pulse && !s_q.run_flag
                        && (sw_run || sw_step))
                    || (sw_run && word_in.interrupt_request));

  // next state of everything
  always_comb begin
    s_d = s_q;

    s_d.parity_tracker = tracker_next;

    // set beats clear, so a lockup is never lost
    if (halt_set) begin
      s_d.halt_flag = 1'b1;
    end else if (halt_clear) begin
      s_d.halt_flag = 1'b0;
    end

    // first-word guard, set only outside time-share
    if (timing_in.phase_end_pulse) begin
      if ((!s_q.run_flag || sw_step) && !word_in.timeshare_cycle
          && !word_in.timeshare_pending) begin
        s_d.first_word_guard = 1'b1;
      end else if (s_q.run_flag && word_in.fetch_phase) begin
        s_d.first_word_guard = 1'b0;
      end
    end

    // run starts from the switch only with halt clear
    if (timing_in.end_of_word_pulse && !s_q.run_flag && !s_q.halt_flag
        && (sw_run || sw_step)) begin
      s_d.run_flag = 1'b1;
    end else if (timing_in.phase_end_pulse && word_in.instruction_end
        && (s_q.halt_flag || sw_step || !sw_run)) begin
      s_d.run_flag = 1'b0;
    end

    // lamps are registered together with the flags, from next state
    s_d.parity_error_lamp = s_d.parity_tracker && s_d.halt_flag;
    s_d.halt_lamp         = !s_d.parity_tracker && s_d.halt_flag;

    // sticky events; a new event wins over a write-one clear
    if (bus_take && avs_write && avs_address == mpc_pkg::ADDR_STATUS) begin
      s_d.status = s_q.status & ~avs_writedata[mpc_pkg::EV_WIDTH-1:0];
    end
    if (!lockup && s_d.parity_tracker && s_d.halt_flag) begin
      s_d.status[mpc_pkg::EV_LOCKUP] = 1'b1;
    end
    if (!s_q.halt_flag && s_d.halt_flag) begin
      s_d.status[mpc_pkg::EV_HALT] = 1'b1;
    end

    // register writes
    if (bus_take && avs_write) begin
      if (avs_address == mpc_pkg::ADDR_MASK) begin
        s_d.mask = avs_writedata[mpc_pkg::EV_WIDTH-1:0];
      end else if (avs_address == mpc_pkg::ADDR_CONTROL) begin
        s_d.control = {31'h0000_0000, avs_writedata[mpc_pkg::CTL_CHECK_EN]};
      end
    end

    s_d.irq = |(s_d.status & s_d.mask);

    // one wait cycle: read data is captured on the edge that drops waitrequest
    s_d.readdata = 32'h0000_0000;
    if (s_q.bus == mpc_pkg::MPC_BUS_IDLE && bus_req) begin
      s_d.bus = mpc_pkg::MPC_BUS_ANSWER;
      if (avs_address == mpc_pkg::ADDR_STATUS) begin
        s_d.readdata[mpc_pkg::EV_WIDTH-1:0] = s_q.status;
      end else if (avs_address == mpc_pkg::ADDR_MASK) begin
        s_d.readdata[mpc_pkg::EV_WIDTH-1:0] = s_q.mask;
      end else if (avs_address == mpc_pkg::ADDR_STATE) begin
        s_d.readdata[mpc_pkg::ST_TRACKER] = s_q.parity_tracker;
        s_d.readdata[mpc_pkg::ST_HALT]    = s_q.halt_flag;
        s_d.readdata[mpc_pkg::ST_GUARD]   = s_q.first_word_guard;
        s_d.readdata[mpc_pkg::ST_RUN]     = s_q.run_flag;
        s_d.readdata[mpc_pkg::ST_LOCKUP]  = lockup;
      end else if (avs_address == mpc_pkg::ADDR_CONTROL) begin
        s_d.readdata = s_q.control;
      end
    end else begin
      s_d.bus = mpc_pkg::MPC_BUS_IDLE;
    end
  end

  // all state in one register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_q         <= '0;
      s_q.control <= mpc_pkg::CTL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign parity_error_out = s_q.parity_error_lamp;
  assign halt_lamp_out    = s_q.halt_lamp;
  assign halt_flag_out    = s_q.halt_flag;
  assign run_flag_out     = s_q.run_flag;
  assign irq_out          = s_q.irq;
  assign avs_readdata     = s_q.readdata;
  assign avs_waitrequest  = (s_q.bus != mpc_pkg::MPC_BUS_ANSWER);

  // checks on the block's own behaviour
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  a_lockup_holds: assert property (
    (lockup && halt_select) |=> (s_q.parity_tracker && s_q.halt_flag))
    else $error("lockup released while halt selected");

  a_error_lamp: assert property (
    parity_error_out == (s_q.parity_tracker && s_q.halt_flag))
    else $error("error lamp does not follow tracker and halt");

  a_halt_on_odd: assert property (
    (s_q.parity_tracker && timing_in.phase_end_pulse && halt_select
     && !word_in.timeshare_cycle) |=> s_q.halt_flag)
    else $error("odd parity did not halt");

  a_tracker_frozen: assert property (
    (s_q.halt_flag && halt_select) |=> $stable(s_q.parity_tracker))
    else $error("tracker moved while halted");

  a_continue_clears: assert property (
    (s_q.halt_flag && !halt_select) |=> !s_q.parity_tracker)
    else $error("continue did not clear tracker");

  a_no_restart_lock: assert property (
    (lockup && word_in.interrupt_request) |=> s_q.halt_flag)
    else $error("interrupt restarted a locked machine");

  a_hold_op_skip: assert property (
    (!s_q.halt_flag && hold_op && word_in.exec_check_phase && !word_in.fetch_phase
     && timing_in.bit_window && !timing_in.phase_end_pulse
     && !timing_in.end_of_word_pulse && !timing_in.q1_pulse)
    |=> $stable(s_q.parity_tracker))
    else $error("phase-5 code was parity checked");

  a_guard_inhibit: assert property (
    (s_q.first_word_guard && word_in.fetch_phase && !word_in.exec_check_phase
     && !s_q.halt_flag && !timing_in.end_of_word_pulse && timing_in.bit_window
     && !timing_in.phase_end_pulse && !timing_in.q1_pulse)
    |=> $stable(s_q.parity_tracker))
    else $error("tracker toggled under first-word guard");

  a_guard_clears: assert property (
    (timing_in.phase_end_pulse && s_q.run_flag && word_in.fetch_phase && !sw_step
     && !word_in.timeshare_pending && !word_in.timeshare_cycle)
    |=> !s_q.first_word_guard)
    else $error("guard not cleared after first fetch");

  a_halt_clear_cond: assert property (
    ($fell(s_q.halt_flag)) |-> $past(!s_q.parity_tracker))
    else $error("halt cleared with tracker set");

  a_halt_lamp: assert property (
    halt_lamp_out == (!s_q.parity_tracker && s_q.halt_flag))
    else $error("halt lamp does not follow tracker and halt");

  a_tracker_preset: assert property (
    (timing_in.phase_end_pulse && !s_q.halt_flag && !word_in.timeshare_cycle
     && word_in.memory_parity_bit) |=> s_q.parity_tracker)
    else $error("tracker not preset from the parity bit");

  a_tracker_toggle: assert property (
    (checked && timing_in.bit_window && !s_q.halt_flag && !timing_in.phase_end_pulse
     && !timing_in.end_of_word_pulse)
    |=> s_q.parity_tracker == ($past(s_q.parity_tracker) ^ $past(word_in.register_serial_out)))
    else $error("tracker did not count a shifted one");

  a_lockup_forms: assert property (
    (s_q.parity_tracker && timing_in.phase_end_pulse && halt_select
     && !word_in.timeshare_cycle) |=> lockup)
    else $error("odd word did not lock tracker and halt");

  a_timeshare_skip: assert property (
    (word_in.timeshare_cycle && !s_q.halt_flag && !timing_in.end_of_word_pulse)
    |=> $stable(s_q.parity_tracker))
    else $error("time-share word was parity checked");

  a_guard_sets: assert property (
    (timing_in.phase_end_pulse && !s_q.run_flag && !word_in.timeshare_cycle
     && !word_in.timeshare_pending) |=> s_q.first_word_guard)
    else $error("guard not set at idle phase end");

  a_no_run_halted: assert property (
    (s_q.halt_flag && !s_q.run_flag) |=> !s_q.run_flag)
    else $error("run started while halted");

  a_check_off: assert property (
    (!check_en && !s_q.halt_flag && timing_in.bit_window && !timing_in.phase_end_pulse
     && !timing_in.end_of_word_pulse && !timing_in.q1_pulse) |=> $stable(s_q.parity_tracker))
    else $error("tracker moved with checking off");

  a_bus_answer: assert property (
    (bus_req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("slave did not answer in one wait cycle");

endmodule : mpc_parity_halt

// ### mpc_pkg.sv
// mpc_pkg: constants, field layouts and carrier types for the
// memory parity check and halt block.
// assumes one bit-time clock shared by the word timing logic.
package mpc_pkg;

  // register byte offsets, one 32-bit word each
  localparam logic [3:0] ADDR_STATUS  = 4'h0;
  localparam logic [3:0] ADDR_MASK    = 4'h4;
  localparam logic [3:0] ADDR_STATE   = 4'h8;
  localparam logic [3:0] ADDR_CONTROL = 4'hc;

  // status and mask bit positions
  localparam int EV_LOCKUP = 0;
  localparam int EV_HALT   = 1;
  localparam int EV_WIDTH  = 2;

  // state register bit positions
  localparam int ST_TRACKER = 0;
  localparam int ST_HALT    = 1;
  localparam int ST_GUARD   = 2;
  localparam int ST_RUN     = 3;
  localparam int ST_LOCKUP  = 4;

  // control register bit positions and reset value
  localparam int                CTL_CHECK_EN = 0;
  localparam logic [31:0] CTL_RESET    = 32'h0000_0001;

  // operation codes that enter the phase-5 hold state (octal in comments)
  localparam int NUM_HOLD_OPS = 12;
  localparam logic [NUM_HOLD_OPS-1:0][5:0] HOLD_OPS = {
    6'h00, 6'h02, 6'h10, 6'h20, 6'h26,          // 00 02 20 40 46
    6'h04, 6'h06, 6'h12, 6'h14, 6'h16, 6'h22, 6'h24 // 04 06 22 24 26 42 44
  };

  // panel input synchroniser depth
  localparam int SYNC_STAGES = 3;
  localparam int PANEL_WIDTH = 3;

  typedef enum logic [0:0] {
    MPC_BUS_IDLE   = 1'b0,
    MPC_BUS_ANSWER = 1'b1
  } mpc_bus_t;

  // word timing pulses from the sequencer
  typedef struct packed {
    logic phase_end_pulse;
    logic end_of_word_pulse;
    logic bit_window;
    logic q1_pulse;
  } mpc_timing_t;

  // word and phase information from memory and decode
  typedef struct packed {
    logic       memory_parity_bit;
    logic       register_serial_out;
    logic       fetch_phase;
    logic       exec_check_phase;
    logic [5:0] op_code;
    logic       instruction_end;
    logic       timeshare_cycle;
    logic       timeshare_pending;
    logic       interrupt_request;
  } mpc_word_t;

  // synchroniser state
  typedef struct packed {
    logic [PANEL_WIDTH-1:0] st1;
    logic [PANEL_WIDTH-1:0] st2;
    logic [PANEL_WIDTH-1:0] st3;
    logic [PANEL_WIDTH-1:0] stable;
  } mpc_sync_t;

  // main block state
  typedef struct packed {
    logic                parity_tracker;
    logic                halt_flag;
    logic                first_word_guard;
    logic                run_flag;
    logic                parity_error_lamp;
    logic                halt_lamp;
    logic                irq;
    logic [EV_WIDTH-1:0] status;
    logic [EV_WIDTH-1:0] mask;
    logic [31:0]         control;
    logic [31:0]         readdata;
    mpc_bus_t            bus;
  } mpc_state_t;

endpackage : mpc_pkg

// ### mpc_panel_sync.sv
// mpc_panel_sync: three-stage synchroniser for the panel switches.
// assumes the switches change slowly against the bit-time clock.
`timescale 1ns/10ps
module mpc_panel_sync (
  // clock and reset
  input  wire logic                             clk_in,
  input  wire logic                             reset_in,
  // raw switch levels and settled copies
  input  wire logic [mpc_pkg::PANEL_WIDTH-1:0]  raw_in,
  output logic      [mpc_pkg::PANEL_WIDTH-1:0]  stable_out
);

  mpc_pkg::mpc_sync_t s_q;
  mpc_pkg::mpc_sync_t s_d;

  // a change counts only once stages two and three agree
  always_comb begin
    s_d        = s_q;
    s_d.st1    = raw_in;
    s_d.st2    = s_q.st1;
    s_d.st3    = s_q.st2;
    s_d.stable = (s_q.st2 & s_q.st3) | (s_q.stable & (s_q.st2 ^ s_q.st3));
  end

  // stage one is read only by stage two
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stable_out = s_q.stable;

endmodule : mpc_panel_sync

// ### mpc_mem_model.sv
// mpc_mem_model: core memory word source and sequencer for the bench.
// assumes the bench raises start_in for one cycle while the model is idle.
`timescale 1ns/10ps
module mpc_mem_model (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               reset_in,
  // word request from the bench
  input  wire logic               start_in,
  input  wire logic               par_in,
  input  wire logic [23:0]        data_in,
  input  wire logic               eow_in,
  input  wire mpc_pkg::mpc_word_t cfg_in,
  // sequencer side towards the block
  output mpc_pkg::mpc_timing_t    timing_out,
  output mpc_pkg::mpc_word_t      word_out,
  output logic                    done_out
);
  logic [4:0]  cnt_q;
  logic        par_q;
  logic [23:0] sh_q;

  // one word: preset pulse, q1 pulse, 24 bit times, then done
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_q <= 5'h00;
      par_q <= 1'b0;
    end else if (cnt_q == 5'h00) begin
      if (start_in) begin
        cnt_q <= 5'h01;
        par_q <= par_in;
        sh_q  <= data_in;
      end
    end else begin
      cnt_q <= (cnt_q == 5'h1b) ? 5'h00 : cnt_q + 5'h01;
      if (timing_out.bit_window) begin
        sh_q <= sh_q >> 1;
      end
    end
  end

  // outside their slots the lines show the inverse or a toggling pattern,
  // so a block that samples at the wrong time cannot get lucky
  always_comb begin
    timing_out = '0;
    word_out = cfg_in;
    timing_out.phase_end_pulse = (cnt_q == 5'h01);
    timing_out.q1_pulse = (cnt_q == 5'h02);
    timing_out.bit_window = (cnt_q >= 5'h03) && (cnt_q <= 5'h1a);
    timing_out.end_of_word_pulse = eow_in;
    word_out.memory_parity_bit = (cnt_q == 5'h01) ? par_q : ~par_q;
    word_out.register_serial_out = timing_out.bit_window ? sh_q[0] : cnt_q[0];
    done_out = (cnt_q == 5'h1b);
  end
endmodule : mpc_mem_model

// ### memory_parity_check_halt_bench.sv
// memory_parity_check_halt_bench: self-checking bench for mpc_parity_halt.
// assumes the word model drives the timing lines and the bench the panel.
`timescale 1ns/10ps
module memory_parity_check_halt_bench;
  logic               clk_in = 1'b0;
  logic               reset_in = 1'b1;
  logic               start = 1'b0;
  logic               par = 1'b0;
  logic               eow = 1'b0;
  logic               sel = 1'b1;
  logic               sw_run = 1'b0;
  logic               sw_step = 1'b0;
  logic               rd = 1'b0;
  logic               wr = 1'b0;
  logic [3:0]         addr = 4'h0;
  logic [23:0]        data = 24'h0000;
  logic [31:0]        wdata = 32'h0000_0000;
  logic [31:0]        lfsr = 32'h0000_0020;
  mpc_pkg::mpc_word_t cfg = '0;
  mpc_pkg::mpc_timing_t timing;
  mpc_pkg::mpc_word_t word;
  logic               done, perr, hlamp, hflag, run, irq, wreq;
  logic [31:0]        rdata;
  logic [31:0]        notes[$];
  int                 n_mismatch = 0;
  int                 compares = 0;
  int                 k;

  always #5 clk_in = ~clk_in;

  mpc_mem_model u_mem (.clk_in(clk_in), .reset_in(reset_in), .start_in(start),
    .par_in(par), .data_in(data), .eow_in(eow), .cfg_in(cfg), .timing_out(timing),
    .word_out(word), .done_out(done));

  mpc_parity_halt u_dut (.clk_in(clk_in), .reset_in(reset_in), .timing_in(timing),
    .word_in(word), .parity_halt_select_in(sel), .control_switch_run_in(sw_run),
    .control_switch_step_in(sw_step), .parity_error_out(perr), .halt_lamp_out(hlamp),
    .halt_flag_out(hflag), .run_flag_out(run), .irq_out(irq), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(wreq));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic timeout();
    n_mismatch++;
    $display("mismatch at %0t: wait ran out", $time);
    stop_test();
  endtask : timeout

  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_in);
      if (wreq === 1'b0) break;
    end
    if (i == 20) timeout();
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rd_exp(input logic [3:0] a, input logic [31:0] e);
    notes.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd_exp

  // one word; the note is the lamp state after its preset pulse has judged
  // the previous word, as {error, halt lamp, halt flag}
  task automatic send(input logic p, input logic [23:0] d, input logic [5:0] op,
                      input logic f, input logic t, input logic [2:0] e);
    int i;
    notes.push_back({29'h0000_0000, e});
    @(posedge clk_in);
    start <= 1'b1;
    par <= p;
    data <= d;
    cfg.op_code <= op;
    cfg.fetch_phase <= f;
    cfg.exec_check_phase <= ~f;
    cfg.timeshare_cycle <= t;
    @(posedge clk_in);
    start <= 1'b0;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_in);
      if (done === 1'b1) break;
    end
    if (i == 40) timeout();
  endtask : send

  task automatic pause(input int n);
    repeat (n) @(posedge clk_in);
  endtask : pause

  task automatic pulse_eow();
    @(posedge clk_in);
    eow <= 1'b1;
    @(posedge clk_in);
    eow <= 1'b0;
  endtask : pulse_eow

  // watcher: each word end or read answer takes the oldest note
  always @(posedge clk_in) begin
    if (done === 1'b1 || (rd === 1'b1 && wreq === 1'b0)) begin
      if (notes.size() == 0) begin
        timeout();
      end else if (done === 1'b1) begin
        check({29'h0000_0000, perr, hlamp, hflag}, notes.pop_front());
      end else begin
        check(rdata, notes.pop_front());
      end
    end
  end

  initial begin
    pause(12);
    reset_in <= 1'b0;
    rd_exp(mpc_pkg::ADDR_CONTROL, mpc_pkg::CTL_RESET);
    rd_exp(mpc_pkg::ADDR_MASK, 32'h0000_0000);
    rd_exp(4'h2, 32'h0000_0000);
    // random words of even weight never halt
    for (k = 0; k < 8; k++) begin
      lfsr = next_rand(lfsr);
      send(^lfsr[23:0], lfsr[23:0], lfsr[29:24], 1'b0, 1'b0, 3'b000);
    end
    // odd words under hold codes are not judged
    for (k = 0; k < mpc_pkg::NUM_HOLD_OPS; k++) begin
      lfsr = next_rand(lfsr);
      send(~^lfsr[23:0], lfsr[23:0], mpc_pkg::HOLD_OPS[k], 1'b0, 1'b0, 3'b000);
    end
    // checking switched off: an odd word passes unjudged
    bus(1'b1, mpc_pkg::ADDR_CONTROL, 32'h0000_0000);
    send(1'b1, 24'h0000, 6'h01, 1'b0, 1'b0, 3'b000);
    bus(1'b1, mpc_pkg::ADDR_CONTROL, mpc_pkg::CTL_RESET);
    send(1'b1, 24'h0000, 6'h01, 1'b0, 1'b1, 3'b000);
    send(1'b1, 24'h0000, 6'h01, 1'b1, 1'b0, 3'b000);
    send(1'b1, 24'h0003, 6'h01, 1'b0, 1'b0, 3'b000);
    // odd word, then a word whose bits would toggle a live tracker
    send(1'b0, 24'h0001, 6'h01, 1'b0, 1'b0, 3'b101);
    send(1'b0, 24'h0001, 6'h01, 1'b0, 1'b0, 3'b101);
    rd_exp(mpc_pkg::ADDR_STATE, 32'h0000_0017);
    bus(1'b1, mpc_pkg::ADDR_STATE, 32'hffff_ffff);
    rd_exp(mpc_pkg::ADDR_STATE, 32'h0000_0017);
    rd_exp(mpc_pkg::ADDR_STATUS, 32'h0000_0003);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    bus(1'b1, mpc_pkg::ADDR_MASK, 32'h0000_0001);
    pause(3);
    check({31'h0000_0000, irq}, 32'h0000_0001);
    bus(1'b1, mpc_pkg::ADDR_STATUS, 32'h0000_0003);
    pause(3);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    rd_exp(mpc_pkg::ADDR_STATUS, 32'h0000_0000);
    // run switch, interrupt and end of word cannot break the lockup
    sw_run <= 1'b1;
    cfg.interrupt_request <= 1'b1;
    pause(6);
    pulse_eow();
    pause(4);
    check({30'h0000_0000, perr, hflag}, 32'h0000_0003);
    check({31'h0000_0000, run}, 32'h0000_0000);
    sw_run <= 1'b0;
    cfg.interrupt_request <= 1'b0;
    // operator: continue first, then step and back to idle
    sel <= 1'b0;
    pause(6);
    check({29'h0000_0000, perr, hlamp, hflag}, 32'h0000_0003);
    sw_step <= 1'b1;
    pause(6);
    pulse_eow();
    pause(4);
    check({29'h0000_0000, perr, hlamp, hflag}, 32'h0000_0000);
    sw_step <= 1'b0;
    pause(6);
    // run from the switch: the first running fetch clears the guard
    sel <= 1'b1;
    sw_run <= 1'b1;
    pause(6);
    pulse_eow();
    pause(2);
    check({31'h0000_0000, run}, 32'h0000_0001);
    send(1'b1, 24'h0001, 6'h01, 1'b1, 1'b0, 3'b000);
    rd_exp(mpc_pkg::ADDR_STATE, 32'h0000_0008);
    send(1'b0, 24'h0001, 6'h01, 1'b1, 1'b0, 3'b000);
    cfg.instruction_end <= 1'b1;
    // odd word halts; the run flag drops at the next instruction end
    send(1'b0, 24'h0000, 6'h01, 1'b1, 1'b0, 3'b101);
    send(1'b0, 24'h0000, 6'h01, 1'b1, 1'b0, 3'b101);
    pause(2);
    check({31'h0000_0000, run}, 32'h0000_0000);
    stop_test();
  end
endmodule : memory_parity_check_halt_bench
